/* hw/eec_ctrl.sv */
// enable and engine execution control register with its gating
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Notes on behaviour
// - enable bit 6 resets to 0; while 0 the device stays in standby
// - standby blocks bits 5:0 here, pwm 16h-1eh and counters 37h-39h
// - setting enable runs a power-up sequence, then normal mode
// - three 2-bit run fields at 5:4, 3:2, 1:0, read/write, reset 00
// - host sets start address via counter registers 37h, 38h, 39h
// - field 00 lets the current instruction finish, then stops
// - a counter is accessible only while its engine field is 00
// - field 01 runs one instruction, counter plus one, field back to 00
// - field 10 runs continuously from the current counter
// - field 11 runs one instruction, counter unchanged, field to 00
// - fields act only while the engine mode is run program
// - counter wraps to zero past its upper limit
// ---------------------------------------------------------------------
module eec_ctrl (
   input wire logic mclk_i,
   input wire logic nrst_i,
   // register port from the serial interface
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // accesses forwarded to the other register files
   output logic pass_wr_o,
   output logic pass_rd_o,
   output logic [7:0] pass_addr_o,
   output logic [7:0] pass_wdata_o,
   // operating modes from the mode register
   input wire logic [1:0] engine_one_operating_mode_i,
   input wire logic [1:0] engine_two_operating_mode_i,
   input wire logic [1:0] engine_three_operating_mode_i,
   // instruction completion from each engine core
   input wire logic instr_done_one_i,
   input wire logic instr_done_two_i,
   input wire logic instr_done_three_i,
   // execute requests to each engine core
   output logic exec_one_o,
   output logic exec_two_o,
   output logic exec_three_o,
   // program counters to each engine core
   output logic [eec_pkg::PC_W-1:0] program_counter_one_o,
   output logic [eec_pkg::PC_W-1:0] program_counter_two_o,
   output logic [eec_pkg::PC_W-1:0] program_counter_three_o,
   // power state
   output logic blocks_powered_o,
   output logic normal_mode_o,
   output logic standby_o
);
   import eec_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic chip_enable;
   logic [1:0] first_engine_run_field;
   logic [1:0] second_engine_run_field;
   logic [1:0] third_engine_run_field;

   logic [NUM_ENGINES-1:0][1:0] run_field;
   logic [NUM_ENGINES-1:0][1:0] op_mode;
   logic [NUM_ENGINES-1:0] done;
   logic [NUM_ENGINES-1:0] run_ok;
   logic [NUM_ENGINES-1:0] field_clr;
   logic [NUM_ENGINES-1:0] pc_wr;
   logic [NUM_ENGINES-1:0] pc_open;
   logic [NUM_ENGINES-1:0] exec;
   logic [NUM_ENGINES-1:0][PC_W-1:0] pc;

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   logic hit_ctrl;
   logic hit_pwm;
   logic [NUM_ENGINES-1:0] hit_pc;
   logic hit_local;
   logic field_wr;
   logic [7:0] next_rdata;

   always_comb begin
      hit_ctrl = 1'b0;
      hit_pc = '0;
      hit_pwm = 1'b0;
      if (reg_addr_i == ADDR_CTRL) begin
         hit_ctrl = 1'b1;
      end else if (reg_addr_i == ADDR_PC_ONE) begin
         hit_pc[0] = 1'b1;
      end else if (reg_addr_i == ADDR_PC_TWO) begin
         hit_pc[1] = 1'b1;
      end else if (reg_addr_i == ADDR_PC_THREE) begin
         hit_pc[2] = 1'b1;
      end else if (reg_addr_i >= ADDR_PWM_FIRST &&
                   reg_addr_i <= ADDR_PWM_LAST) begin
         hit_pwm = 1'b1;
      end
   end

   assign hit_local = hit_ctrl || (hit_pc != '0);
   // run fields only take writes outside standby
   assign field_wr = reg_wr_i && hit_ctrl && chip_enable;

   // ------------------------------------------------------------------
   // enable bit
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         chip_enable <= EN_RESET;
      end else if (reg_wr_i && hit_ctrl) begin
         chip_enable <= reg_wdata_i[EN_BIT];
      end
   end

   // ------------------------------------------------------------------
   // run fields; a host write wins over a self-clear
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         first_engine_run_field <= FIELD_RESET;
      end else if (field_wr) begin
         first_engine_run_field <=
            reg_wdata_i[FIELD_ONE_LSB +: 2];
      end else if (field_clr[0]) begin
         first_engine_run_field <= EXEC_HOLD;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         second_engine_run_field <= FIELD_RESET;
      end else if (field_wr) begin
         second_engine_run_field <=
            reg_wdata_i[FIELD_TWO_LSB +: 2];
      end else if (field_clr[1]) begin
         second_engine_run_field <= EXEC_HOLD;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         third_engine_run_field <= FIELD_RESET;
      end else if (field_wr) begin
         third_engine_run_field <=
            reg_wdata_i[FIELD_THREE_LSB +: 2];
      end else if (field_clr[2]) begin
         third_engine_run_field <= EXEC_HOLD;
      end
   end

   assign run_field[0] = first_engine_run_field;
   assign run_field[1] = second_engine_run_field;
   assign run_field[2] = third_engine_run_field;
   assign op_mode[0] = engine_one_operating_mode_i;
   assign op_mode[1] = engine_two_operating_mode_i;
   assign op_mode[2] = engine_three_operating_mode_i;
   assign done[0] = instr_done_one_i;
   assign done[1] = instr_done_two_i;
   assign done[2] = instr_done_three_i;

   // ------------------------------------------------------------------
   // power-up sequencing
   // ------------------------------------------------------------------
   eec_startup u_startup (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .enable_i(chip_enable),
      .powered_o(blocks_powered_o),
      .normal_o(normal_mode_o)
   );

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         standby_o <= 1'b1;
      end else begin
         standby_o <= !chip_enable;
      end
   end

   // ------------------------------------------------------------------
   // engines
   // ------------------------------------------------------------------
   generate
      for (genvar i = 0; i < NUM_ENGINES; i++) begin : g_eng
         // counter reachable only in hold and outside standby
         assign pc_open[i] = chip_enable &&
            (run_field[i] == EXEC_HOLD);
         assign pc_wr[i] = reg_wr_i && hit_pc[i] && pc_open[i];
         // fields govern only a running engine of a started device
         assign run_ok[i] = normal_mode_o &&
            (op_mode[i] == MODE_RUN);

         eec_engine u_engine (
            .mclk_i(mclk_i),
            .nrst_i(nrst_i),
            .run_ok_i(run_ok[i]),
            .field_i(run_field[i]),
            .done_i(done[i]),
            .pc_wr_i(pc_wr[i]),
            .pc_wdata_i(reg_wdata_i[PC_W-1:0]),
            .exec_o(exec[i]),
            .pc_o(pc[i]),
            .field_clr_o(field_clr[i])
         );
      end
   endgenerate

   assign exec_one_o = exec[0];
   assign exec_two_o = exec[1];
   assign exec_three_o = exec[2];
   assign program_counter_one_o = pc[0];
   assign program_counter_two_o = pc[1];
   assign program_counter_three_o = pc[2];

   // ------------------------------------------------------------------
   // read data
   // ------------------------------------------------------------------
   always_comb begin
      next_rdata = RDATA_RESET;
      if (hit_ctrl) begin
         next_rdata[EN_BIT] = chip_enable;
         if (chip_enable) begin
            next_rdata[FIELD_ONE_LSB +: 2] = first_engine_run_field;
            next_rdata[FIELD_TWO_LSB +: 2] = second_engine_run_field;
            next_rdata[FIELD_THREE_LSB +: 2] = third_engine_run_field;
         end
      end else begin
         for (int k = 0; k < NUM_ENGINES; k++) begin
            if (hit_pc[k] && pc_open[k]) begin
               next_rdata[PC_W-1:0] = pc[k];
            end
         end
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= RDATA_RESET;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i && hit_local;
         if (reg_rd_i && hit_local) begin
            reg_rdata_o <= next_rdata;
         end
      end
   end

   // ------------------------------------------------------------------
   // forwarding; pwm registers are locked in standby
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pass_wr_o <= 1'b0;
         pass_rd_o <= 1'b0;
         pass_addr_o <= ADDR_CTRL;
         pass_wdata_o <= RDATA_RESET;
      end else begin
         pass_wr_o <= reg_wr_i && !hit_local &&
            !(hit_pwm && !chip_enable);
         pass_rd_o <= reg_rd_i && !hit_local &&
            !(hit_pwm && !chip_enable);
         pass_addr_o <= reg_addr_i;
         pass_wdata_o <= reg_wdata_i;
      end
   end

endmodule // eec_ctrl

/* hw/eec_pkg.sv */
// constants and types shared by the enable and execution control bank
package eec_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PC_ONE = 8'h37;
   localparam logic [7:0] ADDR_PC_TWO = 8'h38;
   localparam logic [7:0] ADDR_PC_THREE = 8'h39;
   localparam logic [7:0] ADDR_PWM_FIRST = 8'h16;
   localparam logic [7:0] ADDR_PWM_LAST = 8'h1e;

   // ------------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------------
   localparam int EN_BIT = 6;
   localparam int FIELD_ONE_LSB = 4;
   localparam int FIELD_TWO_LSB = 2;
   localparam int FIELD_THREE_LSB = 0;
   localparam logic EN_RESET = 1'b0;
   localparam logic [1:0] FIELD_RESET = 2'h0;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // ------------------------------------------------------------------
   // engines
   // ------------------------------------------------------------------
   localparam int NUM_ENGINES = 3;
   localparam int PC_W = 7;
   localparam logic [PC_W-1:0] PC_RESET = 7'h00;
   localparam logic [PC_W-1:0] PC_STEP = 7'h01;
   localparam logic [1:0] MODE_RUN = 2'h2;

   typedef enum logic [1:0] {
      EXEC_HOLD = 2'h0,
      EXEC_STEP = 2'h1,
      EXEC_FREE = 2'h2,
      EXEC_ONCE = 2'h3
   } eec_exec_t;

   typedef enum logic {
      ENG_IDLE = 1'b0,
      ENG_BUSY = 1'b1
   } eec_eng_t;

   // ------------------------------------------------------------------
   // power-up sequencing
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      PWR_STANDBY = 2'h0,
      PWR_START = 2'h1,
      PWR_NORMAL = 2'h3
   } eec_pwr_t;

   localparam int CLK_PERIOD_PS = 4000;
   localparam int STARTUP_NS = 1000;
   localparam int STARTUP_CYC =
      (STARTUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STARTUP_W = 8;

endpackage

/* hw/eec_startup.sv */
// power-up sequencer between standby and normal mode
`timescale 1ns/1ps
module eec_startup (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic enable_i,
   output logic powered_o,
   output logic normal_o
);
   import eec_pkg::*;

   eec_pwr_t state;
   eec_pwr_t next_state;
   logic [STARTUP_W-1:0] cnt;
   logic cnt_done;

   assign cnt_done = (cnt == STARTUP_W'(STARTUP_CYC - 1));

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         PWR_STANDBY: begin
            if (enable_i) begin
               next_state = PWR_START;
            end
         end
         PWR_START: begin
            if (!enable_i) begin
               next_state = PWR_STANDBY;
            end else if (cnt_done) begin
               next_state = PWR_NORMAL;
            end
         end
         PWR_NORMAL: begin
            if (!enable_i) begin
               next_state = PWR_STANDBY;
            end
         end
         default: begin
            next_state = PWR_STANDBY;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= PWR_STANDBY;
         powered_o <= 1'b0;
         normal_o <= 1'b0;
      end else begin
         state <= next_state;
         powered_o <= (next_state != PWR_STANDBY);
         normal_o <= (next_state == PWR_NORMAL);
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt <= '0;
      end else if (state == PWR_START && !cnt_done) begin
         cnt <= cnt + STARTUP_W'(1);
      end else if (state != PWR_START) begin
         cnt <= '0;
      end
   end

endmodule // eec_startup

/* hw/eec_engine.sv */
// per-engine execution sequencer and program counter
`timescale 1ns/1ps
module eec_engine (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic run_ok_i,
   input wire logic [1:0] field_i,
   input wire logic done_i,
   input wire logic pc_wr_i,
   input wire logic [eec_pkg::PC_W-1:0] pc_wdata_i,
   output logic exec_o,
   output logic [eec_pkg::PC_W-1:0] pc_o,
   output logic field_clr_o
);
   import eec_pkg::*;

   eec_eng_t state;
   eec_exec_t kind;
   logic start;
   logic finish;

   // new instruction only from idle, in a running mode
   assign start = (state == ENG_IDLE) && run_ok_i &&
      (field_i != EXEC_HOLD);
   assign finish = (state == ENG_BUSY) && done_i;
   // single-shot kinds drop back to hold when done
   assign field_clr_o = finish &&
      (kind == EXEC_STEP || kind == EXEC_ONCE);

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= ENG_IDLE;
         kind <= EXEC_HOLD;
         exec_o <= 1'b0;
      end else begin
         case (state)
            ENG_IDLE: begin
               if (start) begin
                  state <= ENG_BUSY;
                  kind <= eec_exec_t'(field_i);
                  exec_o <= 1'b1;
               end
            end
            ENG_BUSY: begin
               // current instruction always completes
               if (done_i) begin
                  state <= ENG_IDLE;
                  exec_o <= 1'b0;
               end
            end
            default: begin
               state <= ENG_IDLE;
               exec_o <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // program counter
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pc_o <= PC_RESET;
      end else if (pc_wr_i) begin
         pc_o <= pc_wdata_i;
      end else if (finish && kind != EXEC_ONCE) begin
         // wraps to zero past the top address
         pc_o <= pc_o + PC_STEP;
      end
   end

endmodule // eec_engine

/* tb/eec_ctrl_properties.sv */
// port assertions for the enable and execution control register
`timescale 1ns/1ps
module eec_ctrl_properties
   import eec_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic reg_rvalid_o,
   input wire logic pass_wr_o,
   input wire logic pass_rd_o,
   input wire logic [7:0] pass_addr_o,
   input wire logic [1:0] engine_one_operating_mode_i,
   input wire logic instr_done_one_i,
   input wire logic exec_one_o,
   input wire logic [eec_pkg::PC_W-1:0] program_counter_one_o,
   input wire logic blocks_powered_o,
   input wire logic normal_mode_o,
   input wire logic standby_o
);
   localparam int RISE_MIN = STARTUP_CYC - 1;
   localparam int RISE_MAX = STARTUP_CYC + 1;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_power_up;
      $rose(blocks_powered_o);
   endsequence
   sequence s_pwm_access;
      (reg_wr_i || reg_rd_i) && reg_addr_i >= ADDR_PWM_FIRST
         && reg_addr_i <= ADDR_PWM_LAST;
   endsequence
   chk_ctrl_read_answer:
      assert property (reg_rd_i && reg_addr_i == ADDR_CTRL |=> reg_rvalid_o)
      else $error("control read not answered");
   chk_pwm_blocked:
      assert property (s_pwm_access ##1 standby_o
         |-> !pass_wr_o && !pass_rd_o && !reg_rvalid_o)
      else $error("pwm access passed in standby");
   chk_other_forward:
      assert property (reg_wr_i && reg_addr_i == 8'h02
         |=> pass_wr_o && pass_addr_o == 8'h02)
      else $error("write not forwarded");
   chk_normal_powered:
      assert property (normal_mode_o |-> blocks_powered_o)
      else $error("normal mode without power");
   chk_start_wait:
      assert property (s_power_up |-> !normal_mode_o [*8])
      else $error("normal mode too early");
   chk_start_end:
      assert property (s_power_up |-> ##[RISE_MIN:RISE_MAX] $rose(normal_mode_o))
      else $error("startup length wrong");
   chk_exec_holds:
      assert property (exec_one_o && !instr_done_one_i |=> exec_one_o)
      else $error("instruction abandoned");
   chk_pc_only_exec:
      assert property (!exec_one_o && !reg_wr_i
         |=> $stable(program_counter_one_o))
      else $error("counter moved while idle");
   chk_exec_needs_normal:
      assert property ($rose(exec_one_o) |-> $past(normal_mode_o))
      else $error("engine ran outside normal mode");
   chk_exec_needs_run:
      assert property ($rose(exec_one_o)
         |-> $past(engine_one_operating_mode_i) == MODE_RUN)
      else $error("engine ran outside run mode");
endmodule // eec_ctrl_properties

bind eec_ctrl eec_ctrl_properties eec_ctrl_properties_inst (.mclk_i,
   .nrst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rvalid_o, .pass_wr_o,
   .pass_rd_o, .pass_addr_o, .engine_one_operating_mode_i,
   .instr_done_one_i, .exec_one_o, .program_counter_one_o,
   .blocks_powered_o, .normal_mode_o, .standby_o);

/* tb/eec_core_model.sv */
// engine core stand-in answering execute requests after a set delay
`timescale 1ns/1ps
module eec_core_model (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic exec_i,
   input wire logic [3:0] delay_i,
   output logic done_o
);
   logic [3:0] wait_cnt;
   // one done pulse per request, delay_i cycles after it is seen
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wait_cnt <= 4'h0;
         done_o <= 1'b0;
      end else if (exec_i && !done_o && wait_cnt >= delay_i) begin
         wait_cnt <= 4'h0;
         done_o <= 1'b1;
      end else begin
         wait_cnt <= (exec_i && !done_o) ? wait_cnt + 4'h1 : 4'h0;
         done_o <= 1'b0;
      end
   end
endmodule // eec_core_model

/* tb/test_eec_ctrl.sv */
// self-checking bench for the enable and execution control register
`timescale 1ns/1ps
module test_eec_ctrl;
   import eec_pkg::*;
   logic mclk_i, nrst_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pass_addr_o, pass_wdata_o;
   logic pass_wr_o, pass_rd_o, blocks_powered_o, normal_mode_o, standby_o;
   logic [1:0] engine_one_operating_mode_i, engine_two_operating_mode_i;
   logic [1:0] engine_three_operating_mode_i;
   logic instr_done_one_i, instr_done_two_i, instr_done_three_i;
   logic exec_one_o, exec_two_o, exec_three_o;
   logic [PC_W-1:0] program_counter_one_o, program_counter_two_o;
   logic [PC_W-1:0] program_counter_three_o;
   int bad_count = 0;
   int comparisons = 0;

   eec_ctrl eec_ctrl_inst (.mclk_i, .nrst_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .pass_wr_o,
      .pass_rd_o, .pass_addr_o, .pass_wdata_o, .engine_one_operating_mode_i,
      .engine_two_operating_mode_i, .engine_three_operating_mode_i,
      .instr_done_one_i, .instr_done_two_i, .instr_done_three_i,
      .exec_one_o, .exec_two_o, .exec_three_o, .program_counter_one_o,
      .program_counter_two_o, .program_counter_three_o, .blocks_powered_o,
      .normal_mode_o, .standby_o);
   eec_core_model core_one_inst (.mclk_i, .nrst_i, .exec_i(exec_one_o),
      .delay_i(4'h0), .done_o(instr_done_one_i));
   eec_core_model core_two_inst (.mclk_i, .nrst_i, .exec_i(exec_two_o),
      .delay_i(4'h2), .done_o(instr_done_two_i));
   eec_core_model core_three_inst (.mclk_i, .nrst_i, .exec_i(exec_three_o),
      .delay_i(4'h5), .done_o(instr_done_three_i));

   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic cmp(input logic [7:0] got, exp, input string what);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
            exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      @(negedge mclk_i);
   endtask
   task automatic rdchk(input logic [7:0] a, exp, input string what);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      @(negedge mclk_i);
      cmp({7'h0, reg_rvalid_o}, 8'h01, what);
      cmp(reg_rdata_o, exp, what);
   endtask
   // read of a forwarded address; judges the pass strobe
   task automatic rdpass(input logic [7:0] a, exp, input string what);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      @(negedge mclk_i);
      cmp({7'h0, pass_rd_o}, exp, what);
   endtask
   // wait until every engine has gone idle
   task automatic settle;
      int n;
      repeat (3) @(negedge mclk_i);
      for (n = 0; n < 60 && (exec_one_o || exec_two_o || exec_three_o); n++)
         @(negedge mclk_i);
      cmp({7'h0, exec_one_o | exec_two_o | exec_three_o}, 8'h00, "idle");
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_standby;
      cmp({7'h0, standby_o}, 8'h01, "standby after reset");
      rdchk(ADDR_CTRL, 8'h00, "control reset");
      wr(ADDR_CTRL, 8'h3f);
      rdchk(ADDR_CTRL, 8'h00, "fields locked");
      wr(ADDR_PC_ONE, 8'h12);
      rdchk(ADDR_PC_ONE, 8'h00, "counter locked");
      wr(ADDR_PWM_FIRST, 8'h33);
      cmp({7'h0, pass_wr_o}, 8'h00, "pwm first blocked");
      wr(ADDR_PWM_LAST, 8'h33);
      cmp({7'h0, pass_wr_o}, 8'h00, "pwm last blocked");
      wr(8'h02, 8'h5a);
      cmp({7'h0, pass_wr_o}, 8'h01, "other write passed");
      cmp(pass_wdata_o, 8'h5a, "other write data");
      rdpass(ADDR_PWM_FIRST, 8'h00, "pwm read blocked");
      rdpass(8'h02, 8'h01, "other read passed");
   endtask
   task automatic t_enable;
      int n;
      wr(ADDR_CTRL, 8'h40);
      @(negedge mclk_i);
      cmp({7'h0, blocks_powered_o}, 8'h01, "blocks powered");
      for (n = 0; n < 300 && !normal_mode_o; n++) @(negedge mclk_i);
      cmp({7'h0, n >= STARTUP_CYC - 1 && n <= STARTUP_CYC + 1}, 8'h01,
         "startup length");
      cmp({7'h0, standby_o}, 8'h00, "left standby");
      rdpass(ADDR_PWM_LAST, 8'h01, "pwm read open");
   endtask
   task automatic t_counters;
      logic [7:0] start [3] = '{8'h7f, 8'h05, 8'h09};
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_PC_ONE + 8'(i), start[i] | 8'h80);
         rdchk(ADDR_PC_ONE + 8'(i), start[i], "counter set");
      end
   endtask
   task automatic t_step_once;
      wr(ADDR_CTRL, 8'h50);
      settle();
      cmp({1'b0, program_counter_one_o}, 8'h00, "step wraps");
      rdchk(ADDR_CTRL, 8'h40, "step clears field");
      wr(ADDR_CTRL, 8'h4c);
      settle();
      cmp({1'b0, program_counter_two_o}, 8'h05, "once keeps pc");
      rdchk(ADDR_CTRL, 8'h40, "once clears field");
   endtask
   task automatic t_no_run;
      logic seen = 1'b0;
      @(posedge mclk_i) engine_one_operating_mode_i <= 2'h0;
      wr(ADDR_CTRL, 8'h50);
      repeat (20) begin
         @(negedge mclk_i);
         seen |= exec_one_o;
      end
      cmp({7'h0, seen}, 8'h00, "no run outside run mode");
      @(posedge mclk_i) engine_one_operating_mode_i <= MODE_RUN;
      settle();
      cmp({1'b0, program_counter_one_o}, 8'h01, "step after run");
   endtask
   task automatic t_free_hold;
      logic [PC_W-1:0] p;
      wr(ADDR_CTRL, 8'h42);
      repeat (60) @(negedge mclk_i);
      cmp({7'h0, program_counter_three_o > 7'h09}, 8'h01, "free run");
      rdchk(ADDR_PC_THREE, 8'h00, "counter hidden");
      wr(ADDR_CTRL, 8'h40);
      settle();
      p = program_counter_three_o;
      repeat (10) @(negedge mclk_i);
      cmp({1'b0, program_counter_three_o}, {1'b0, p}, "hold stops");
      rdchk(ADDR_PC_THREE, {1'b0, p}, "counter visible");
   endtask
   task automatic t_disable;
      logic seen = 1'b0;
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CTRL, 8'h10);
      repeat (20) begin
         @(negedge mclk_i);
         seen |= exec_one_o;
      end
      cmp({7'h0, seen}, 8'h00, "no run disabled");
      cmp({7'h0, standby_o}, 8'h01, "standby again");
      rdchk(ADDR_CTRL, 8'h00, "field write ignored");
      // enabling write from standby must leave the fields untouched
      wr(ADDR_CTRL, 8'h7f);
      rdchk(ADDR_CTRL, 8'h40, "fields kept");
   endtask

   initial begin
      repeat (5000) @(posedge mclk_i);
      bad_count++;
      give_verdict();
   end

   initial begin
      nrst_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      engine_one_operating_mode_i = MODE_RUN;
      engine_two_operating_mode_i = MODE_RUN;
      engine_three_operating_mode_i = MODE_RUN;
      repeat (12) @(posedge mclk_i);
      nrst_i <= 1'b1;
      t_standby();
      t_enable();
      t_counters();
      t_step_once();
      t_no_run();
      t_free_hold();
      t_disable();
      give_verdict();
   end
endmodule // test_eec_ctrl
